// [src/mpc_mode_pin_cfg.sv]
// Mode and pin configuration register with watchdog and pin routing
`timescale 1ns/1ps
module mpc_mode_pin_cfg
#(
   parameter logic [31:0] WD_T0_CYC = mpc_pkg::MPC_WD_T0_CYC,
   parameter logic [31:0] WD_T1_CYC = mpc_pkg::MPC_WD_T1_CYC,
   parameter logic [31:0] WD_T2_CYC = mpc_pkg::MPC_WD_T2_CYC,
   parameter logic [31:0] WD_T3_CYC = mpc_pkg::MPC_WD_T3_CYC,
   parameter logic [31:0] PULSE_CYC = mpc_pkg::MPC_PULSE_CYC
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata_r,
   input wire logic watchdog_en,
   input wire logic wd_irq_clr,
   input wire mpc_pkg::mpc_irq_t irq_in,
   input wire logic general_pin1_in,
   output logic general_pin1_out_r,
   output logic general_pin1_oe_r,
   output logic out2_pin_r,
   output logic supply_control_pin_r,
   output logic supply_control_pin_oe_r,
   output logic wake_request_pin_out_r,
   output logic wake_request_pin_oe_r,
   output logic wake_req_rail_r,
   output logic wd_irq_flag_r,
   output logic standby_req_r,
   output logic ref_is_40m_r,
   output logic test_mode_r,
   output logic failsafe_en_r
);

   // ------------------------------------------------------------
   // Configuration storage
   // ------------------------------------------------------------
   mpc_pkg::mpc_cfg_t cfg_r;
   logic kick_r;
   logic timeout;
   logic pin1_sync;
   logic pin1_prev_r;
   logic pin_kick;
   logic host_kick;
   logic [31:0] period_cyc;
   mpc_pkg::mpc_pulse_state_t state_r;
   mpc_pkg::mpc_pulse_state_t state_nxt;
   logic [31:0] pulse_cnt_r;
   logic pulse_done;
   logic wdo_level_r;

   // Only defined fields are stored; reserved bits are never kept
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cfg_r.wd_period_sel <= mpc_pkg::MPC_WD_PERIOD_RST;
         cfg_r.ref_sel <= mpc_pkg::MPC_REF_SEL_RST;
         cfg_r.out2_source_sel <= mpc_pkg::MPC_OUT2_SRC_RST;
         cfg_r.test_en <= mpc_pkg::MPC_TEST_EN_RST;
         cfg_r.wake_req_rail_sel <= mpc_pkg::MPC_WAKE_RAIL_RST;
         cfg_r.watchdog_timeout_action <= mpc_pkg::MPC_WATCHDOG_TIMEOUT_ACTION_RST;
         cfg_r.pin1_direction_sel <= mpc_pkg::MPC_PIN1_DIR_RST;
         cfg_r.failsafe_en <= mpc_pkg::MPC_FAILSAFE_RST;
         cfg_r.pin1_output_source_sel <= mpc_pkg::MPC_PIN1_SRC_RST;
         cfg_r.supply_ctrl_pin_off <= mpc_pkg::MPC_SUPPLY_OFF_RST;
         cfg_r.wake_req_function_sel <= mpc_pkg::MPC_WAKE_FUNC_RST;
      end
      else if (reg_wr)
      begin
         cfg_r.wd_period_sel <= reg_wdata[mpc_pkg::MPC_WD_PERIOD_POS +: 2];
         cfg_r.ref_sel <= reg_wdata[mpc_pkg::MPC_REF_SEL_POS];
         cfg_r.out2_source_sel <= reg_wdata[mpc_pkg::MPC_OUT2_SRC_POS +: 2];
         cfg_r.test_en <= reg_wdata[mpc_pkg::MPC_TEST_EN_POS];
         cfg_r.wake_req_rail_sel <= reg_wdata[mpc_pkg::MPC_WAKE_RAIL_POS];
         cfg_r.watchdog_timeout_action <= reg_wdata[mpc_pkg::MPC_WATCHDOG_TIMEOUT_ACTION_POS +: 2];
         cfg_r.pin1_direction_sel <= reg_wdata[mpc_pkg::MPC_PIN1_DIR_POS +: 2];
         cfg_r.failsafe_en <= reg_wdata[mpc_pkg::MPC_FAILSAFE_POS];
         cfg_r.pin1_output_source_sel <= reg_wdata[mpc_pkg::MPC_PIN1_SRC_POS +: 2];
         cfg_r.supply_ctrl_pin_off <= reg_wdata[mpc_pkg::MPC_SUPPLY_OFF_POS];
         cfg_r.wake_req_function_sel <= reg_wdata[mpc_pkg::MPC_WAKE_FUNC_POS];
      end
   end

   // ------------------------------------------------------------
   // Read-back
   // ------------------------------------------------------------
   // One cycle behind the state, so a read sees a settled word
   always_ff @(posedge mclk)
   begin
      if (rst)
         reg_rdata_r <= 32'h0;
      else
      begin
         reg_rdata_r <= 32'h0;
         reg_rdata_r[mpc_pkg::MPC_WD_PERIOD_POS +: 2] <= cfg_r.wd_period_sel;
         reg_rdata_r[mpc_pkg::MPC_REF_SEL_POS] <= cfg_r.ref_sel;
         reg_rdata_r[mpc_pkg::MPC_OUT2_SRC_POS +: 2] <= cfg_r.out2_source_sel;
         reg_rdata_r[mpc_pkg::MPC_TEST_EN_POS] <= cfg_r.test_en;
         reg_rdata_r[mpc_pkg::MPC_WAKE_RAIL_POS] <= cfg_r.wake_req_rail_sel;
         reg_rdata_r[mpc_pkg::MPC_WD_KICK_POS] <= kick_r;
         reg_rdata_r[mpc_pkg::MPC_WATCHDOG_TIMEOUT_ACTION_POS +: 2] <= cfg_r.watchdog_timeout_action;
         reg_rdata_r[mpc_pkg::MPC_PIN1_DIR_POS +: 2] <= cfg_r.pin1_direction_sel;
         reg_rdata_r[mpc_pkg::MPC_FAILSAFE_POS] <= cfg_r.failsafe_en;
         reg_rdata_r[mpc_pkg::MPC_PIN1_SRC_POS +: 2] <= cfg_r.pin1_output_source_sel;
         reg_rdata_r[mpc_pkg::MPC_SUPPLY_OFF_POS] <= cfg_r.supply_ctrl_pin_off;
         reg_rdata_r[mpc_pkg::MPC_WAKE_FUNC_POS] <= cfg_r.wake_req_function_sel;
      end
   end

   // ------------------------------------------------------------
   // Watchdog trigger sources
   // ------------------------------------------------------------
   mpc_sync2 u_pin1_sync
   (
      .mclk(mclk),
      .rst(rst),
      .d(general_pin1_in),
      .q(pin1_sync)
   );

   always_ff @(posedge mclk)
   begin
      if (rst)
         pin1_prev_r <= 1'h0;
      else
         pin1_prev_r <= pin1_sync;
   end

   // Rising edge on pin 1 kicks only while it is configured as input
   assign pin_kick = (cfg_r.pin1_direction_sel == mpc_pkg::MPC_DIR_IN)
                     && pin1_sync && !pin1_prev_r;
   assign host_kick = reg_wr && reg_wdata[mpc_pkg::MPC_WD_KICK_POS];

   always_comb
   begin
      case (cfg_r.wd_period_sel)
         2'h0: period_cyc = WD_T0_CYC;
         2'h1: period_cyc = WD_T1_CYC;
         2'h2: period_cyc = WD_T2_CYC;
         default: period_cyc = WD_T3_CYC;
      endcase
   end

   mpc_watchdog_period_sel u_watchdog_period_sel
   (
      .mclk(mclk),
      .rst(rst),
      .enable(watchdog_en),
      .restart(host_kick || pin_kick),
      .limit(period_cyc),
      .timeout(timeout)
   );

   // ------------------------------------------------------------
   // Kick bit and watchdog flag
   // ------------------------------------------------------------
   // Timeout wins over a kick landing in the same cycle
   always_ff @(posedge mclk)
   begin
      if (rst)
         kick_r <= mpc_pkg::MPC_WD_KICK_RST;
      else if (timeout)
         kick_r <= 1'h1;
      else if (host_kick)
         kick_r <= 1'h0;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         wd_irq_flag_r <= 1'h0;
      else if (timeout)
         wd_irq_flag_r <= 1'h1;
      else if (wd_irq_clr)
         wd_irq_flag_r <= 1'h0;
   end

   // ------------------------------------------------------------
   // Timeout action sequencer
   // ------------------------------------------------------------
   assign pulse_done = (pulse_cnt_r >= PULSE_CYC - 32'h1);

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         mpc_pkg::MPC_IDLE:
         begin
            if (timeout && cfg_r.watchdog_timeout_action == mpc_pkg::MPC_ACT_SUPPLY)
               state_nxt = mpc_pkg::MPC_SUPPLY_PULSE;
            else if (timeout && cfg_r.watchdog_timeout_action == mpc_pkg::MPC_ACT_WDO)
               state_nxt = mpc_pkg::MPC_WDO_PULSE;
         end
         mpc_pkg::MPC_SUPPLY_PULSE,
         mpc_pkg::MPC_WDO_PULSE:
         begin
            if (pulse_done)
               state_nxt = mpc_pkg::MPC_IDLE;
         end
         default:
         begin
            state_nxt = mpc_pkg::MPC_IDLE;
         end
      endcase
   end

   // Reserved action code only raises the flag and the kick bit
   always_ff @(posedge mclk)
   begin
      if (rst)
         state_r <= mpc_pkg::MPC_IDLE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge mclk)
   begin
      if (rst || state_r == mpc_pkg::MPC_IDLE)
         pulse_cnt_r <= 32'h0;
      else
         pulse_cnt_r <= pulse_cnt_r + 32'h1;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         standby_req_r <= 1'h0;
      else
         standby_req_r <= timeout && cfg_r.watchdog_timeout_action == mpc_pkg::MPC_ACT_SUPPLY;
   end

   // Watchdog output, active low: held by flag or pulsed
   always_ff @(posedge mclk)
   begin
      if (rst)
         wdo_level_r <= 1'h1;
      else if (state_nxt == mpc_pkg::MPC_WDO_PULSE)
         wdo_level_r <= 1'h0;
      else if (cfg_r.watchdog_timeout_action == mpc_pkg::MPC_ACT_IRQ)
         wdo_level_r <= !(wd_irq_flag_r || timeout);
      else
         wdo_level_r <= 1'h1;
   end

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         out2_pin_r <= 1'h1;
      end
      else
      begin
         case (cfg_r.out2_source_sel)
            mpc_pkg::MPC_OUT2_CORE0: out2_pin_r <= !irq_in.can_core_irq[0];
            mpc_pkg::MPC_OUT2_WDO: out2_pin_r <= wdo_level_r;
            mpc_pkg::MPC_OUT2_IRQ: out2_pin_r <= irq_in.irq_out_pin;
            default: out2_pin_r <= 1'h1;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         general_pin1_out_r <= 1'h1;
         general_pin1_oe_r <= 1'h0;
      end
      else
      begin
         general_pin1_oe_r <= (cfg_r.pin1_direction_sel == mpc_pkg::MPC_DIR_OUT);
         case (cfg_r.pin1_output_source_sel)
            mpc_pkg::MPC_SRC_SPI: general_pin1_out_r <= !irq_in.spi_fault_irq;
            mpc_pkg::MPC_SRC_CORE1: general_pin1_out_r <= !irq_in.can_core_irq[1];
            mpc_pkg::MPC_SRC_UVT: general_pin1_out_r <= !irq_in.uv_thermal_irq;
            default: general_pin1_out_r <= 1'h1;
         endcase
      end
   end

   // Supply pin idles high; a disabled pin is released, not driven
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         supply_control_pin_r <= 1'h1;
         supply_control_pin_oe_r <= 1'h1;
      end
      else
      begin
         supply_control_pin_r <= (state_nxt != mpc_pkg::MPC_SUPPLY_PULSE);
         supply_control_pin_oe_r <= !cfg_r.supply_ctrl_pin_off;
      end
   end

   // On the io rail the wake pin is open drain: enable only to pull low
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wake_request_pin_out_r <= 1'h1;
         wake_request_pin_oe_r <= 1'h1;
         wake_req_rail_r <= mpc_pkg::MPC_WAKE_RAIL_RST;
      end
      else
      begin
         wake_req_rail_r <= cfg_r.wake_req_rail_sel;
         if (cfg_r.wake_req_function_sel)
         begin
            wake_request_pin_out_r <= !irq_in.wake_irq;
            wake_request_pin_oe_r <= !cfg_r.wake_req_rail_sel || irq_in.wake_irq;
         end
         else
         begin
            wake_request_pin_out_r <= supply_control_pin_r;
            wake_request_pin_oe_r <= !cfg_r.wake_req_rail_sel || !supply_control_pin_r;
         end
      end
   end

   // ------------------------------------------------------------
   // Mode outputs
   // ------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ref_is_40m_r <= mpc_pkg::MPC_REF_SEL_RST;
         test_mode_r <= mpc_pkg::MPC_TEST_EN_RST;
         failsafe_en_r <= mpc_pkg::MPC_FAILSAFE_RST;
      end
      else
      begin
         ref_is_40m_r <= cfg_r.ref_sel;
         test_mode_r <= cfg_r.test_en;
         failsafe_en_r <= cfg_r.failsafe_en;
      end
   end

endmodule

// [src/mpc_pkg.sv]
// Package with field layout, reset values, timing and types of the mode and pin config register
package mpc_pkg;

   // ------------------------------------------------------------
   // Register layout
   // ------------------------------------------------------------
   localparam logic [15:0] MPC_CFG_OFFSET = 16'h0800;
   localparam int MPC_WD_PERIOD_POS = 28;
   localparam int MPC_REF_SEL_POS = 27;
   localparam int MPC_OUT2_SRC_POS = 22;
   localparam int MPC_TEST_EN_POS = 21;
   localparam int MPC_WAKE_RAIL_POS = 19;
   localparam int MPC_WD_KICK_POS = 18;
   localparam int MPC_WATCHDOG_TIMEOUT_ACTION_POS = 16;
   localparam int MPC_PIN1_DIR_POS = 14;
   localparam int MPC_FAILSAFE_POS = 13;
   localparam int MPC_PIN1_SRC_POS = 10;
   localparam int MPC_SUPPLY_OFF_POS = 9;
   localparam int MPC_WAKE_FUNC_POS = 8;

   // ------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------
   localparam logic [1:0] MPC_WD_PERIOD_RST = 2'h0;
   localparam logic MPC_REF_SEL_RST = 1'h1;
   localparam logic [1:0] MPC_OUT2_SRC_RST = 2'h0;
   localparam logic MPC_TEST_EN_RST = 1'h0;
   localparam logic MPC_WAKE_RAIL_RST = 1'h0;
   localparam logic MPC_WD_KICK_RST = 1'h0;
   localparam logic [1:0] MPC_WATCHDOG_TIMEOUT_ACTION_RST = 2'h0;
   localparam logic [1:0] MPC_PIN1_DIR_RST = 2'h0;
   localparam logic MPC_FAILSAFE_RST = 1'h0;
   localparam logic [1:0] MPC_PIN1_SRC_RST = 2'h1;
   localparam logic MPC_SUPPLY_OFF_RST = 1'h0;
   localparam logic MPC_WAKE_FUNC_RST = 1'h0;

   // ------------------------------------------------------------
   // Field codes
   // ------------------------------------------------------------
   localparam logic [1:0] MPC_ACT_IRQ = 2'h0;
   localparam logic [1:0] MPC_ACT_SUPPLY = 2'h1;
   localparam logic [1:0] MPC_ACT_WDO = 2'h2;
   localparam logic [1:0] MPC_OUT2_NONE = 2'h0;
   localparam logic [1:0] MPC_OUT2_CORE0 = 2'h1;
   localparam logic [1:0] MPC_OUT2_WDO = 2'h2;
   localparam logic [1:0] MPC_OUT2_IRQ = 2'h3;
   localparam logic [1:0] MPC_DIR_OUT = 2'h0;
   localparam logic [1:0] MPC_DIR_IN = 2'h2;
   localparam logic [1:0] MPC_SRC_SPI = 2'h0;
   localparam logic [1:0] MPC_SRC_CORE1 = 2'h1;
   localparam logic [1:0] MPC_SRC_UVT = 2'h2;

   // ------------------------------------------------------------
   // Timing at 125 MHz
   // ------------------------------------------------------------
   localparam longint MPC_CLK_KHZ = 125000;
   localparam longint MPC_WD_T0_MS = 60;
   localparam longint MPC_WD_T1_MS = 600;
   localparam longint MPC_WD_T2_MS = 3000;
   localparam longint MPC_WD_T3_MS = 6000;
   localparam longint MPC_PULSE_MS = 300;
   localparam logic [31:0] MPC_WD_T0_CYC = 32'(MPC_WD_T0_MS * MPC_CLK_KHZ);
   localparam logic [31:0] MPC_WD_T1_CYC = 32'(MPC_WD_T1_MS * MPC_CLK_KHZ);
   localparam logic [31:0] MPC_WD_T2_CYC = 32'(MPC_WD_T2_MS * MPC_CLK_KHZ);
   localparam logic [31:0] MPC_WD_T3_CYC = 32'(MPC_WD_T3_MS * MPC_CLK_KHZ);
   localparam logic [31:0] MPC_PULSE_CYC = 32'(MPC_PULSE_MS * MPC_CLK_KHZ);

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] wd_period_sel;
      logic ref_sel;
      logic [1:0] out2_source_sel;
      logic test_en;
      logic wake_req_rail_sel;
      logic [1:0] watchdog_timeout_action;
      logic [1:0] pin1_direction_sel;
      logic failsafe_en;
      logic [1:0] pin1_output_source_sel;
      logic supply_ctrl_pin_off;
      logic wake_req_function_sel;
   } mpc_cfg_t;

   typedef struct packed {
      logic [1:0] can_core_irq;
      logic irq_out_pin;
      logic spi_fault_irq;
      logic uv_thermal_irq;
      logic wake_irq;
   } mpc_irq_t;

   typedef enum logic [2:0] {
      MPC_IDLE = 3'h1,
      MPC_SUPPLY_PULSE = 3'h2,
      MPC_WDO_PULSE = 3'h4
   } mpc_pulse_state_t;

endpackage

// [src/mpc_sync2.sv]
// Two-stage synchroniser for a pin input
`timescale 1ns/1ps
module mpc_sync2
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic d,
   output logic q
);
   logic meta_r;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         meta_r <= 1'h0;
         q <= 1'h0;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// [src/mpc_watchdog_period_sel.sv]
// Watchdog period counter with restart and timeout pulse
`timescale 1ns/1ps
module mpc_watchdog_period_sel
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic enable,
   input wire logic restart,
   input wire logic [31:0] limit,
   output logic timeout
);
   logic [31:0] count_r;

   always_ff @(posedge mclk)
   begin
      if (rst || restart || !enable)
      begin
         count_r <= 32'h0;
         timeout <= 1'h0;
      end
      else if (count_r >= limit - 32'h1)
      begin
         count_r <= 32'h0;
         timeout <= 1'h1;
      end
      else
      begin
         count_r <= count_r + 32'h1;
         timeout <= 1'h0;
      end
   end
endmodule

// [bench/mpc_host.sv]
// Host model writing the config register and driving pin 1 from outside
`timescale 1ns/1ps
module mpc_host
(
   input wire logic mclk,
   output logic reg_wr,
   output logic [31:0] reg_wdata,
   output logic pin1_drv
);
   // ---------------------------------------------
   // Host side drivers
   // ---------------------------------------------
   initial
   begin
      reg_wr = 1'h0;
      reg_wdata = 32'h0;
      pin1_drv = 1'h0;
   end
   // Strobe stays up so bursts run back to back; a burst ends with idle
   task automatic write(input logic [31:0] w);
      @(negedge mclk);
      reg_wr = 1'h1;
      reg_wdata = w;
   endtask
   task automatic idle();
      @(negedge mclk);
      reg_wr = 1'h0;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic kick(input logic [31:0] w);
      write(w | 32'h00040000);
   endtask
   task automatic pin_pulse();
      @(negedge mclk);
      pin1_drv = 1'h1;
      repeat (3) @(negedge mclk);
      pin1_drv = 1'h0;
   endtask
endmodule

// [bench/mpc_mode_pin_cfg_chk.sv]
// Port checker for the mode and pin config register
`timescale 1ns/1ps
module mpc_mode_pin_cfg_chk
#(
   parameter logic [31:0] PULSE_CYC = 32'h0000000a
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata_r,
   input wire logic wd_irq_clr,
   input wire logic general_pin1_oe_r,
   input wire logic out2_pin_r,
   input wire logic supply_control_pin_r,
   input wire logic supply_control_pin_oe_r,
   input wire logic wd_irq_flag_r,
   input wire logic standby_req_r,
   input wire logic ref_is_40m_r,
   input wire logic test_mode_r
);
   logic [31:0] low_cnt_r;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ---------------------------------------------
   // Helper and properties
   // ---------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst || supply_control_pin_r)
         low_cnt_r <= 32'h0;
      else
         low_cnt_r <= low_cnt_r + 32'h1;
   end
   // Kick bit masked: a timeout may set it between write and read-back
   AST_READBACK: assert property (reg_wr |-> ##2
      (reg_rdata_r & 32'hfffbffff) == ($past(reg_wdata, 2) & 32'h38ebef00))
      else $error("read-back differs from written word");
   AST_RSVD_ZERO: assert property ((reg_rdata_r & 32'hc71010ff) == 32'h0)
      else $error("reserved bits read nonzero");
   AST_REF_SEL: assert property (reg_wr |-> ##2 ref_is_40m_r == $past(reg_wdata[27], 2))
      else $error("reference select does not follow write");
   AST_TEST_MODE: assert property (reg_wr |-> ##2 test_mode_r == $past(reg_wdata[21], 2))
      else $error("test mode does not follow write");
   AST_SUPPLY_OE: assert property (reg_wr |-> ##2
      supply_control_pin_oe_r == !$past(reg_wdata[9], 2))
      else $error("supply pin enable wrong");
   AST_PIN1_DIR: assert property (reg_wr |-> ##2
      general_pin1_oe_r == ($past(reg_wdata[15:14], 2) == 2'h0))
      else $error("pin 1 direction wrong");
   AST_FLAG_HOLD: assert property (wd_irq_flag_r && !wd_irq_clr |=> wd_irq_flag_r)
      else $error("watchdog flag dropped without clear");
   AST_KICK_SET: assert property ($rose(wd_irq_flag_r) |=> reg_rdata_r[18])
      else $error("kick bit not set on timeout");
   AST_STANDBY: assert property ($fell(supply_control_pin_r) |->
      standby_req_r ##1 !standby_req_r)
      else $error("standby request missing on supply pulse");
   AST_SUPPLY_LEN: assert property ($rose(supply_control_pin_r) |->
      low_cnt_r >= PULSE_CYC && low_cnt_r <= PULSE_CYC + 32'h1)
      else $error("supply pulse length wrong");
   AST_WDO_IRQ: assert property ((wd_irq_flag_r && reg_rdata_r[23:22] == 2'h2
      && reg_rdata_r[17:16] == 2'h0) [*3] |-> !out2_pin_r)
      else $error("watchdog output not low while flag set");
endmodule
// Checker default pulse length must equal the bench's short pulse
bind mpc_mode_pin_cfg mpc_mode_pin_cfg_chk u_chk (.mclk, .rst,
   .reg_wr, .reg_wdata, .reg_rdata_r, .wd_irq_clr, .general_pin1_oe_r, .out2_pin_r,
   .supply_control_pin_r, .supply_control_pin_oe_r, .wd_irq_flag_r, .standby_req_r,
   .ref_is_40m_r, .test_mode_r);

// [bench/test_mode_pin_config_watchdog.sv]
// Self-checking bench for the mode and pin config register
`timescale 1ns/1ps
module test_mode_pin_config_watchdog;
   typedef struct packed {
      logic [31:0] word;
      mpc_pkg::mpc_irq_t irq;
      logic out2;
      logic pin1;
   } mpc_row_t;
   localparam logic [31:0] T_CYC [4] = '{32'h28, 32'h3c, 32'h50, 32'h64};
   localparam mpc_row_t ROWS [6] = '{'{32'h00400000, 6'h1c, 1'h0, 1'h0},
      '{32'h00400000, 6'h22, 1'h1, 1'h1}, '{32'h00c00400, 6'h20, 1'h0, 1'h0},
      '{32'h00c00800, 6'h0a, 1'h1, 1'h0}, '{32'h00000c00, 6'h37, 1'h1, 1'h1},
      '{32'h00800800, 6'h00, 1'h1, 1'h1}};
   logic mclk, rst, reg_wr, watchdog_en, wd_irq_clr, pin1_drv, pin1_lvl;
   logic [31:0] reg_wdata, reg_rdata_r;
   mpc_pkg::mpc_irq_t irq_in;
   logic p1_out, p1_oe, out2, sup, sup_oe, wk_out, wk_oe, rail, flag, stby, ref40, tmode, fsafe;
   int bad_count = 0;
   int checks_done = 0;
   int cyc_count = 0;
   assign pin1_lvl = p1_oe ? p1_out : pin1_drv;
   mpc_host HOST (.mclk(mclk), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .pin1_drv(pin1_drv));
   mpc_mode_pin_cfg #(.WD_T0_CYC(T_CYC[0]), .WD_T1_CYC(T_CYC[1]), .WD_T2_CYC(T_CYC[2]),
      .WD_T3_CYC(T_CYC[3]), .PULSE_CYC(32'ha)) DUT (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .watchdog_en(watchdog_en),
      .wd_irq_clr(wd_irq_clr), .irq_in(irq_in), .general_pin1_in(pin1_lvl),
      .general_pin1_out_r(p1_out), .general_pin1_oe_r(p1_oe), .out2_pin_r(out2),
      .supply_control_pin_r(sup), .supply_control_pin_oe_r(sup_oe),
      .wake_request_pin_out_r(wk_out), .wake_request_pin_oe_r(wk_oe),
      .wake_req_rail_r(rail), .wd_irq_flag_r(flag), .standby_req_r(stby),
      .ref_is_40m_r(ref40), .test_mode_r(tmode), .failsafe_en_r(fsafe));
   // ---------------------------------------------
   // Clock, limit and helpers
   // ---------------------------------------------
   initial mclk = 1'h0;
   always #4 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc_count++;
      if (cyc_count == 20000)
      begin
         bad_count++;
         finish_test();
      end
   end
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ---------------------------------------------
   // Sequence
   // ---------------------------------------------
   initial
   begin
      int n;
      rst = 1'h1;
      watchdog_en = 1'h0;
      wd_irq_clr = 1'h0;
      irq_in = '0;
      cycles(6);
      rst = 1'h0;
      cycles(3);
      check_word(reg_rdata_r, 32'h08000400);
      check_bit(ref40, 1'h1);
      check_bit(out2, 1'h1);
      check_bit(tmode, 1'h0);
      check_bit(rail, 1'h0);
      check_bit(wk_oe, 1'h1);
      check_bit(fsafe, 1'h0);
      check_bit(sup_oe, 1'h1);
      check_bit(wk_out, sup);
      foreach (ROWS[i])
      begin
         irq_in = ROWS[i].irq;
         HOST.write(ROWS[i].word);
         HOST.idle();
         cycles(3);
         check_word(reg_rdata_r, ROWS[i].word);
         check_bit(out2, ROWS[i].out2);
         check_bit(p1_out, ROWS[i].pin1);
      end
      HOST.write(32'hffffffff);
      HOST.idle();
      cycles(3);
      check_word(reg_rdata_r, 32'h38ebef00);
      check_bit(tmode, 1'h1);
      check_bit(fsafe, 1'h1);
      check_bit(rail, 1'h1);
      check_bit(sup_oe, 1'h0);
      check_bit(p1_oe, 1'h0);
      check_bit(wk_out, 1'h1);
      check_bit(wk_oe, 1'h0);
      // Open drain on the io rail: released while idle, driven when asserting
      irq_in = 6'h01;
      cycles(2);
      check_bit(wk_out, 1'h0);
      check_bit(wk_oe, 1'h1);
      HOST.write(32'hffffffff);
      HOST.write(32'h0);
      HOST.idle();
      cycles(3);
      check_word(reg_rdata_r, 32'h0);
      check_bit(ref40, 1'h0);
      for (int i = 0; i < 4; i++)
      begin
         HOST.write({2'h0, 2'(i), 4'h0, 2'h2, 4'h0, 2'(i), 16'h0});
         HOST.idle();
         cycles(3);
         watchdog_en = 1'h1;
         n = 0;
         while (flag !== 1'h1 && n < 1000)
         begin
            @(negedge mclk);
            n++;
         end
         check_bit(n >= T_CYC[i] && n <= T_CYC[i] + 4, 1'h1);
         check_bit(flag, 1'h1);
         cycles(2);
         watchdog_en = 1'h0;
         check_bit(reg_rdata_r[18], 1'h1);
         check_bit(out2, 1'(i));
         check_bit(sup, i != 1);
         wd_irq_clr = 1'h1;
         cycles(1);
         wd_irq_clr = 1'h0;
         cycles(15);
         check_bit(flag, 1'h0);
         check_bit(out2, 1'h1);
         check_bit(sup, 1'h1);
      end
      HOST.write(32'h0);
      HOST.idle();
      watchdog_en = 1'h1;
      repeat (3)
      begin
         cycles(30);
         HOST.kick(32'h0);
         HOST.idle();
      end
      cycles(2);
      check_bit(flag, 1'h0);
      check_bit(reg_rdata_r[18], 1'h0);
      HOST.write(32'h00008000);
      HOST.idle();
      repeat (3)
      begin
         cycles(20);
         HOST.pin_pulse();
      end
      check_bit(flag, 1'h0);
      check_bit(p1_oe, 1'h0);
      cycles(60);
      check_bit(flag, 1'h1);
      // Reset in mid-run, with the flag set and the watchdog running
      rst = 1'h1;
      cycles(2);
      rst = 1'h0;
      cycles(3);
      check_word(reg_rdata_r, 32'h08000400);
      check_bit(flag, 1'h0);
      finish_test();
   end
endmodule
